// ---- tsr_cfg.svh ----
// register pointers, field positions, reset values and hysteresis counts of the sensor
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH

// register pointers
`define TSR_PTR_CRIT 8'h04
`define TSR_PTR_RESULT 8'h05
`define TSR_PTR_MAKER 8'h06
`define TSR_PTR_PART 8'h07
`define TSR_PTR_TIMEOUT 8'h22
`define TSR_PTR_RST 8'h00

// field positions
`define TSR_BIT_CRIT_HIGH 15
`define TSR_BIT_ABOVE_UPPER 14
`define TSR_BIT_BELOW_LOWER 13
`define TSR_TEMP_MSB 12
`define TSR_TEMP_LSB 1
`define TSR_LIM_LSB 2
`define TSR_TO_BIT 7

// reset values
`define TSR_RST_WORD 16'h0000
`define TSR_RST_LIMIT 11'h000
`define TSR_RST_TEMP 12'h000
`define TSR_RST_BYTE 8'h00

// hysteresis in 0.125 degree steps: 0, 1.5, 3 and 6 degrees
`define TSR_HYST_ZERO 14'sd0
`define TSR_HYST_1P5 14'sd12
`define TSR_HYST_3 14'sd24
`define TSR_HYST_6 14'sd48

// trip unit indices
`define TSR_U_CRIT 0
`define TSR_U_UPPER 1
`define TSR_U_LOWER 2
`define TSR_U_ALERT 3
`define TSR_UNITS 4

`endif

// ---- tsr_pkg.sv ----
// shared types of the temperature sensor register block
`default_nettype none
package tsr_pkg;
  // one byte-level request from the two-wire slave engine
  typedef struct packed {
    logic ptr_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] data;
  } tsr_req_t;

  // one byte answer to a data read
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tsr_rsp_t;

  typedef enum logic [1:0] {TSR_HYS_ZERO, TSR_HYS_1P5, TSR_HYS_3, TSR_HYS_6} tsr_hyst_t;
  typedef enum logic {TSR_PH_HIGH, TSR_PH_LOW} tsr_phase_t;
  typedef logic signed [13:0] tsr_temp_t;
endpackage
`default_nettype wire

// ---- tsr_trip_flag.sv ----
// one temperature trip flag with optional hysteresis on release
`default_nettype none
module tsr_trip_flag #(
  parameter bit SET_ON_EQ = 1'b0,
  parameter bit LOW_SIDE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic update,
  input wire tsr_pkg::tsr_temp_t temp,
  input wire tsr_pkg::tsr_temp_t limit,
  input wire tsr_pkg::tsr_temp_t hyst,
  output logic flag_q
);
  import tsr_pkg::*;

  logic set_c;
  logic clr_c;
  tsr_temp_t release_lvl;

  // low side releases at the limit itself, high side at or below limit minus hysteresis
  assign release_lvl = tsr_temp_t'(limit - hyst);
  assign set_c = LOW_SIDE ? (temp < limit) : (SET_ON_EQ ? (temp >= limit) : (temp > limit));
  assign clr_c = LOW_SIDE ? (temp >= limit) : (temp <= release_lvl);

  // set wins when both hold at equality with zero hysteresis
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flag_q <= 1'b0;
    end
    else if (!en)
    begin
      flag_q <= 1'b0;
    end
    else if (update && set_c)
    begin
      flag_q <= 1'b1;
    end
    else if (update && clr_c)
    begin
      flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tsr_regs.sv ----
// register side of the temperature sensor: limit, result, identity and timeout control
// Function
// - critical limit register at pointer 04h, sign bit 12, value bits 11..2.
// - enabled alert sets above critical limit, releases at limit minus hysteresis.
// - critical limit becomes read-only while its lock bit is set.
// - critical limit bits 15..13 and 1..0 read zero and ignore writes.
// - read-only result at 05h, temperature in bits 12..1, bit 0 zero.
// - result status bits come only from comparisons, never from the alert.
// - bit 15 sets at or above critical, clears at limit minus hysteresis.
// - bit 14 sets above upper limit, clears at upper minus hysteresis.
// - bit 13 sets below lower limit, clears at or above it, no hysteresis.
// - bit 12 is the sign in result and limit registers.
// - bit 11 weighs 128 degrees, halving down to 0.125 at bit 1.
// - register 06h always returns a fixed maker code.
// - register 07h returns part code high byte and revision low byte.
// - register 22h bit 7 disables the bus timeout, reset zero, others read zero.
// - timeout bit ignores writes while either limit lock is set.
// - host writes a pointer first; the pointer is kept for later reads.
// - each register moves as two bytes, high byte first.
`include "tsr_cfg.svh"
`default_nettype none
module tsr_regs #(
  parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire tsr_pkg::tsr_req_t host_req,
  output tsr_pkg::tsr_rsp_t host_rsp,
  input wire logic [11:0] meas_temp,
  input wire logic meas_valid,
  input wire logic [10:0] upper_limit,
  input wire logic [10:0] lower_limit,
  input wire logic crit_lock,
  input wire logic win_lock,
  input wire tsr_pkg::tsr_hyst_t hyst_sel,
  input wire logic alert_enable,
  output logic crit_alert,
  output logic timeout_disable
);
  import tsr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ptr_q;
  tsr_phase_t phase_q;
  logic [7:0] hold_q;
  logic [15:0] snap_q;
  tsr_rsp_t rsp_q;
  logic [10:0] crit_q;
  logic [11:0] temp_q;
  logic to_dis_q;
  logic [`TSR_UNITS-1:0] trip_q;
  logic [15:0] crit_word;
  logic [15:0] result_word;
  logic [15:0] read_word;
  logic commit;
  logic [15:0] wr_word;
  tsr_temp_t temp_ext;
  tsr_temp_t hyst_c;
  tsr_temp_t lim_a [`TSR_UNITS];

  //////////////////////////////////////////////////////////////////////////////
  // pointer and byte phase
  // a new pointer always restarts the pair at the high byte
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_q <= `TSR_PTR_RST;
    end
    else if (host_req.ptr_wr)
    begin
      ptr_q <= host_req.data;
    end
  end

  // high byte then low byte, shared by reads and writes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_q <= TSR_PH_HIGH;
    end
    else if (host_req.ptr_wr)
    begin
      phase_q <= TSR_PH_HIGH;
    end
    else if (host_req.data_wr || host_req.data_rd)
    begin
      phase_q <= (phase_q == TSR_PH_HIGH) ? TSR_PH_LOW : TSR_PH_HIGH;
    end
  end

  // the high byte of a write waits until the low byte completes the word
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_q <= `TSR_RST_BYTE;
    end
    else if (!host_req.ptr_wr && host_req.data_wr && phase_q == TSR_PH_HIGH)
    begin
      hold_q <= host_req.data;
    end
  end

  assign commit = !host_req.ptr_wr && host_req.data_wr && phase_q == TSR_PH_LOW;
  assign wr_word = {hold_q, host_req.data};

  //////////////////////////////////////////////////////////////////////////////
  // writable registers
  // only the value field is stored, so unused bits cannot take a write
  // read-only pointers have no write path at all, the byte is simply dropped
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      crit_q <= `TSR_RST_LIMIT;
    end
    else if (commit && ptr_q == `TSR_PTR_CRIT && !crit_lock)
    begin
      crit_q <= wr_word[`TSR_TEMP_MSB:`TSR_LIM_LSB];
    end
  end

  // either lock freezes the timeout bit, so a locked part keeps its bus behaviour
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      to_dis_q <= 1'b0;
    end
    else if (commit && ptr_q == `TSR_PTR_TIMEOUT && !(crit_lock || win_lock))
    begin
      to_dis_q <= wr_word[`TSR_TO_BIT];
    end
  end

  assign timeout_disable = to_dis_q;

  //////////////////////////////////////////////////////////////////////////////
  // measurement capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      temp_q <= `TSR_RST_TEMP;
    end
    else if (meas_valid)
    begin
      temp_q <= meas_temp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // comparisons, all in signed 0.125 degree steps
  // limits have 0.25 degree steps, so a zero is appended below them
  assign temp_ext = tsr_temp_t'({{2{meas_temp[11]}}, meas_temp});

  always_comb
  begin
    lim_a[`TSR_U_CRIT] = tsr_temp_t'({{2{crit_q[10]}}, crit_q, 1'b0});
    lim_a[`TSR_U_UPPER] = tsr_temp_t'({{2{upper_limit[10]}}, upper_limit, 1'b0});
    lim_a[`TSR_U_LOWER] = tsr_temp_t'({{2{lower_limit[10]}}, lower_limit, 1'b0});
    lim_a[`TSR_U_ALERT] = tsr_temp_t'({{2{crit_q[10]}}, crit_q, 1'b0});
  end

  // selected hysteresis
  always_comb
  begin
    unique case (hyst_sel)
      TSR_HYS_ZERO: hyst_c = `TSR_HYST_ZERO;
      TSR_HYS_1P5: hyst_c = `TSR_HYST_1P5;
      TSR_HYS_3: hyst_c = `TSR_HYST_3;
      TSR_HYS_6: hyst_c = `TSR_HYST_6;
    endcase
  end

  // status flags and alert are separate units, so the flags never follow the alert
  localparam logic [`TSR_UNITS-1:0] SET_EQ_V = 4'h1;
  localparam logic [`TSR_UNITS-1:0] LOW_V = 4'h4;
  localparam logic [`TSR_UNITS-1:0] GATED_V = 4'h8;

  genvar gi;
  generate
    for (gi = 0; gi < `TSR_UNITS; gi++)
    begin : g_trip
      tsr_trip_flag #(
        .SET_ON_EQ(SET_EQ_V[gi]),
        .LOW_SIDE(LOW_V[gi])
      ) u_trip (
        .sys_clk(sys_clk),
        .rst(rst),
        .en(GATED_V[gi] ? alert_enable : 1'b1),
        .update(meas_valid),
        .temp(temp_ext),
        .limit(lim_a[gi]),
        .hyst(LOW_V[gi] ? `TSR_HYST_ZERO : hyst_c),
        .flag_q(trip_q[gi])
      );
    end
  endgenerate

  assign crit_alert = trip_q[`TSR_U_ALERT];

  //////////////////////////////////////////////////////////////////////////////
  // read words
  assign crit_word = {3'b000, crit_q, 2'b00};
  assign result_word = {trip_q[`TSR_U_CRIT], trip_q[`TSR_U_UPPER], trip_q[`TSR_U_LOWER],
                        temp_q, 1'b0};

  // unknown pointers read as zero
  always_comb
  begin
    case (ptr_q)
      `TSR_PTR_CRIT: read_word = crit_word;
      `TSR_PTR_RESULT: read_word = result_word;
      `TSR_PTR_MAKER: read_word = MAKER_CODE;
      `TSR_PTR_PART: read_word = {PART_CODE, REVISION};
      `TSR_PTR_TIMEOUT: read_word = {8'h00, to_dis_q, 7'h00};
      default: read_word = `TSR_RST_WORD;
    endcase
  end

  // the low byte comes from a snapshot so a word cannot tear between its bytes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      snap_q <= `TSR_RST_WORD;
    end
    else if (!host_req.ptr_wr && !host_req.data_wr && host_req.data_rd &&
             phase_q == TSR_PH_HIGH)
    begin
      snap_q <= read_word;
    end
  end

  // answer one cycle after the request
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_q <= '0;
    end
    else
    begin
      rsp_q.valid <= !host_req.ptr_wr && !host_req.data_wr && host_req.data_rd;
      if (!host_req.ptr_wr && !host_req.data_wr && host_req.data_rd)
      begin
        rsp_q.data <= (phase_q == TSR_PH_HIGH) ? read_word[15:8] : snap_q[7:0];
      end
    end
  end

  assign host_rsp = rsp_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic rd_go;
  assign rd_go = !host_req.ptr_wr && !host_req.data_wr && host_req.data_rd;

  chk_crit_lock_hold: assert property (
    commit && ptr_q == `TSR_PTR_CRIT && crit_lock |=> $stable(crit_q))
    else $error("critical limit changed while locked");

  chk_crit_write_take: assert property (
    commit && ptr_q == `TSR_PTR_CRIT && !crit_lock
    |=> crit_word == {3'b000, $past(wr_word[12:2]), 2'b00})
    else $error("critical limit write not stored");

  chk_crit_unused_zero: assert property (
    crit_word[15:13] == 3'b000 && crit_word[1:0] == 2'b00)
    else $error("unused limit bits not zero");

  chk_result_low_bit: assert property (
    meas_valid |=> result_word[12:0] == {$past(meas_temp), 1'b0})
    else $error("result does not show measurement");

  chk_timeout_lock: assert property (
    commit && ptr_q == `TSR_PTR_TIMEOUT && (crit_lock || win_lock) |=> $stable(to_dis_q))
    else $error("timeout bit changed while locked");

  chk_crit_flag_set: assert property (
    meas_valid && temp_ext >= lim_a[`TSR_U_CRIT] |=> result_word[`TSR_BIT_CRIT_HIGH])
    else $error("critical flag not set");

  chk_upper_flag_set: assert property (
    meas_valid && temp_ext > lim_a[`TSR_U_UPPER] |=> result_word[`TSR_BIT_ABOVE_UPPER])
    else $error("upper flag not set");

  chk_lower_flag_clr: assert property (
    meas_valid && temp_ext >= lim_a[`TSR_U_LOWER] |=> !result_word[`TSR_BIT_BELOW_LOWER])
    else $error("lower flag not cleared");

  chk_alert_set: assert property (
    alert_enable && meas_valid && temp_ext > lim_a[`TSR_U_ALERT] ##1 alert_enable
    |-> crit_alert)
    else $error("alert not raised above critical limit");

  chk_id_word: assert property (
    rd_go && phase_q == TSR_PH_HIGH && ptr_q == `TSR_PTR_MAKER
    |=> host_rsp.valid && host_rsp.data == MAKER_CODE[15:8])
    else $error("maker code high byte wrong");

  chk_read_pair: assert property (
    rd_go && phase_q == TSR_PH_HIGH ##1 rd_go && !host_req.ptr_wr
    |=> host_rsp.valid && host_rsp.data == $past(snap_q[7:0]))
    else $error("low byte does not match high byte word");

  chk_timeout_take: assert property (
    commit && ptr_q == `TSR_PTR_TIMEOUT && !(crit_lock || win_lock)
    |=> timeout_disable == $past(wr_word[`TSR_TO_BIT]))
    else $error("timeout bit write not stored");

  chk_alert_off: assert property (
    !alert_enable |=> !crit_alert)
    else $error("alert raised while disabled");

  chk_alert_release: assert property (
    meas_valid && temp_ext <= tsr_temp_t'(lim_a[`TSR_U_ALERT] - hyst_c) |=> !crit_alert)
    else $error("alert not released at limit minus hysteresis");

  chk_ptr_keep: assert property (
    !host_req.ptr_wr |=> $stable(ptr_q))
    else $error("pointer changed without a pointer write");

  chk_ro_write_drop: assert property (
    commit && (ptr_q == `TSR_PTR_RESULT || ptr_q == `TSR_PTR_MAKER || ptr_q == `TSR_PTR_PART)
    |=> $stable(crit_q) && $stable(to_dis_q))
    else $error("write to read-only register changed state");

  cov_timeout_set: cover property (commit && ptr_q == `TSR_PTR_TIMEOUT ##1 $rose(timeout_disable));
  cov_alert_up: cover property (meas_valid ##1 $rose(crit_alert));
  cov_locked_write: cover property (commit && ptr_q == `TSR_PTR_CRIT && crit_lock);
  cov_result_pair: cover property (rd_go && ptr_q == `TSR_PTR_RESULT ##1 rd_go);
endmodule
`default_nettype wire

// ---- tsr_host_model.sv ----
// host-side byte requester that reaches the sensor registers through the pointer
`default_nettype none
module tsr_host_model (
  input wire logic sys_clk,
  output tsr_pkg::tsr_req_t host_req
);
  import tsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // quiet at start, no strobe raised before the bench asks for one
  initial host_req = '0;

  // one request per edge, launched by nba so the design samples it settled
  task automatic put(input logic [2:0] s, input logic [7:0] d);
  begin
    @(posedge sys_clk);
    host_req <= {s, d};
  end
  endtask

  // released data lines flip so a stale byte never passes for a fresh one
  task automatic idle();
  begin
    @(posedge sys_clk);
    host_req <= {3'b000, ~host_req.data};
  end
  endtask

  task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] w);
  begin
    put(3'b100, ptr);
    put(3'b010, w[15:8]);
    put(3'b010, w[7:0]);
    idle();
  end
  endtask

  // np low reuses the pointer already held by the device
  task automatic rd_reg(input logic [7:0] ptr, input bit np);
  begin
    if (np)
      put(3'b100, ptr);
    put(3'b001, 8'($urandom));
    put(3'b001, 8'($urandom));
    idle();
  end
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the sensor register block
`include "tsr_cfg.svh"
`default_nettype none
module tb_top;
  import tsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MAKER = 16'h0c3a; // arbitrary value
  localparam logic [7:0] PART = 8'h6e; // arbitrary value
  localparam logic [7:0] REV = 8'h03; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  tsr_req_t host_req;
  tsr_rsp_t host_rsp;
  logic [11:0] meas_temp = 12'h000;
  logic meas_valid = 1'b0;
  logic [10:0] upper_limit = 11'h000;
  logic [10:0] lower_limit = 11'h000;
  logic crit_lock = 1'b0;
  logic win_lock = 1'b0;
  tsr_hyst_t hyst_sel = TSR_HYS_ZERO;
  logic alert_enable = 1'b0;
  logic crit_alert;
  logic timeout_disable;
  logic [7:0] exp_q[$];
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] crit_w = 16'h0000;
  logic e_crit = 1'b0;
  logic e_up = 1'b0;
  logic e_lo = 1'b0;
  logic e_alert = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  tsr_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION(REV)) uut (
    .sys_clk(sys_clk), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
    .meas_temp(meas_temp), .meas_valid(meas_valid), .upper_limit(upper_limit),
    .lower_limit(lower_limit), .crit_lock(crit_lock), .win_lock(win_lock),
    .hyst_sel(hyst_sel), .alert_enable(alert_enable), .crit_alert(crit_alert),
    .timeout_disable(timeout_disable));
  tsr_host_model host (.sys_clk(sys_clk), .host_req(host_req));

  always #5 sys_clk = ~sys_clk;

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
  begin
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
  begin
    chk_byte(what, {7'h00, e}, {7'h00, g});
  end
  endtask

  task automatic summarize();
  begin
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  // watcher: every answered byte takes the oldest note; also cuts a hang short
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
    else if (host_rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk_byte("unexpected read", 8'hxx, host_rsp.data);
      else
        chk_byte("read byte", exp_q.pop_front(), host_rsp.data);
    end
  end

  // note the expected high then low byte, then read them
  task automatic rd(input logic [7:0] ptr, input logic [15:0] w, input bit np = 1'b1);
  begin
    exp_q.push_back(w[15:8]);
    exp_q.push_back(w[7:0]);
    host.rd_reg(ptr, np);
    repeat (2) @(posedge sys_clk);
  end
  endtask

  // one measurement; the reference flags follow it with the same inputs
  // np high reloads the pointer; low relies on the device keeping the result pointer
  task automatic meas(input logic [11:0] t, input logic en, input bit np);
    tsr_temp_t tv;
    tsr_temp_t c;
    tsr_temp_t u;
    tsr_temp_t l;
    tsr_temp_t h;
  begin
    @(posedge sys_clk);
    meas_temp <= t;
    meas_valid <= 1'b1;
    alert_enable <= en;
    tv = {t[11], t[11], t};
    c = {crit_w[12], crit_w[12], crit_w[12:2], 1'b0};
    u = {upper_limit[10], upper_limit[10], upper_limit, 1'b0};
    l = {lower_limit[10], lower_limit[10], lower_limit, 1'b0};
    h = (hyst_sel == TSR_HYS_1P5) ? `TSR_HYST_1P5 : (hyst_sel == TSR_HYS_3) ? `TSR_HYST_3 :
        (hyst_sel == TSR_HYS_6) ? `TSR_HYST_6 : `TSR_HYST_ZERO;
    e_crit = (tv >= c) ? 1'b1 : (tv <= c - h) ? 1'b0 : e_crit;
    e_up = (tv > u) ? 1'b1 : (tv <= u - h) ? 1'b0 : e_up;
    e_lo = tv < l;
    e_alert = !en ? 1'b0 : (tv > c) ? 1'b1 : (tv <= c - h) ? 1'b0 : e_alert;
    @(posedge sys_clk);
    meas_valid <= 1'b0;
    #1;
    chk_bit("crit_alert", e_alert, crit_alert);
    rd(8'h05, {e_crit, e_up, e_lo, t, 1'b0}, np);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [10:0] v;
    logic [15:0] w;
    void'($urandom(7));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h04, 16'h0000);
    rd(8'h05, 16'h0000);
    rd(8'h22, 16'h0000);
    rd(8'h06, MAKER);
    rd(8'h07, {PART, REV});
    rd(8'h00, 16'h0000);
    host.wr_reg(8'h06, 16'ha5a5);
    host.wr_reg(8'h07, 16'h0000);
    rd(8'h06, MAKER);
    rd(8'h07, {PART, REV});
    host.wr_reg(8'h04, 16'hffff);
    rd(8'h04, 16'h1ffc);
    crit_lock <= 1'b1;
    host.wr_reg(8'h04, 16'h0000);
    rd(8'h04, 16'h1ffc);
    crit_lock <= 1'b0;
    host.wr_reg(8'h22, 16'hffff);
    rd(8'h22, 16'h0080);
    // each lock alone must freeze the timeout bit
    for (int i = 0; i < 2; i++)
    begin
      {crit_lock, win_lock} <= 2'b01 << i;
      host.wr_reg(8'h22, 16'h0000);
      rd(8'h22, 16'h0080);
      chk_bit("timeout_disable", 1'b1, timeout_disable);
    end
    {crit_lock, win_lock} <= 2'b00;
    host.wr_reg(8'h22, 16'h0000);
    rd(8'h22, 16'h0000);
    chk_bit("timeout_disable", 1'b0, timeout_disable);
    // limits near zero so temperatures cross them and the hysteresis bands
    for (int i = 0; i < 60; i++)
    begin
      @(posedge sys_clk);
      upper_limit <= 11'($urandom_range(0, 16)) - 11'd8;
      lower_limit <= 11'($urandom_range(0, 16)) - 11'd8;
      hyst_sel <= tsr_hyst_t'($urandom_range(0, 3));
      if (i % 5 == 0)
      begin
        v = 11'($urandom_range(0, 16)) - 11'd8;
        w = 16'($urandom);
        w[12:2] = v;
        host.wr_reg(8'h04, w);
        crit_w = {3'b000, v, 2'b00};
        rd(8'h04, crit_w);
      end
      meas(12'($urandom_range(0, 127)) - 12'd64, i % 7 != 3, i % 5 == 0);
    end
    summarize();
  end
endmodule
`default_nettype wire
